//--- rtl/fdsp_defs.svh
`ifndef FDSP_DEFS_SVH
`define FDSP_DEFS_SVH

// Operation codes.
`define FDSP_OP_WRITE_STATUS  8'h01
`define FDSP_OP_PROGRAM       8'h02
`define FDSP_OP_READ          8'h03
`define FDSP_OP_WRITE_DISABLE 8'h04
`define FDSP_OP_READ_STATUS   8'h05
`define FDSP_OP_WRITE_ENABLE  8'h06
`define FDSP_OP_SUB_ERASE     8'h20
`define FDSP_OP_SECT_ERASE    8'hd8
`define FDSP_OP_BULK_ERASE    8'hc7
`define FDSP_OP_DIE_ERASE     8'hc4
`define FDSP_OP_WIDE_ENTER    8'hb7
`define FDSP_OP_WIDE_EXIT     8'he9

// Status register layout.
`define FDSP_ST_WIP       0
`define FDSP_ST_WEL       1
`define FDSP_ST_BP_LSB    2
`define FDSP_ST_BP_LO     3
`define FDSP_ST_BP_MID    4
`define FDSP_ST_TB        5
`define FDSP_ST_BP_HI     6
`define FDSP_ST_WRITABLE  8'hfc
`define FDSP_ST_RESET     8'h00

// Framing and array geometry.
`define FDSP_BYTE_BITS    16'd8
`define FDSP_HDR_NARROW   16'd32
`define FDSP_HDR_WIDE     16'd40
`define FDSP_SUB_LSB      12
`define FDSP_SECT_LSB     16
`define FDSP_READ_FILL    8'hff

// Cycle times.
`define FDSP_CLK_PERIOD_NS     40
`define FDSP_T_STATUS_WR_NS    5000
`define FDSP_T_PROG_NS         80000
`define FDSP_T_SUB_ERASE_NS    40000000
`define FDSP_T_SECT_ERASE_NS   700000000
`define FDSP_T_BULK_ERASE_NS   2000000000

`endif

//--- rtl/fdsp_pkg.sv
package fdsp_pkg;

    typedef enum logic [1:0]
    {
        FDSP_D128 = 2'b00,
        FDSP_D256 = 2'b01,
        FDSP_D512 = 2'b10
    } fdsp_density_t;

    typedef enum logic
    {
        FDSP_IDLE = 1'b0,
        FDSP_BUSY = 1'b1
    } fdsp_state_t;

    typedef enum logic [2:0]
    {
        FDSP_CMD_PROGRAM    = 3'b000,
        FDSP_CMD_SUB_ERASE  = 3'b001,
        FDSP_CMD_SECT_ERASE = 3'b010,
        FDSP_CMD_BULK_ERASE = 3'b011,
        FDSP_CMD_DIE_ERASE  = 3'b100
    } fdsp_cmd_kind_t;

    typedef struct packed
    {
        fdsp_cmd_kind_t kind;
        logic [31:0]    addr;
        logic [9:0]     sector;
        logic [13:0]    subsector;
        logic [7:0]     data;
    } fdsp_cmd_t;

    typedef struct packed
    {
        logic [7:0]  opcode;
        logic [31:0] addr;
        logic [7:0]  data;
        logic [15:0] bit_count;
        logic        frame_tog;
    } fdsp_frame_t;

endpackage

//--- rtl/fdsp_link_shifter.sv
`timescale 1ns/1ps
`include "fdsp_defs.svh"

module fdsp_link_shifter
(
    input  wire logic                 serial_clk,
    input  wire logic                 select_n,
    input  wire logic                 link_rst,
    input  wire logic                 data_in,
    input  wire logic                 wide_mode,
    input  wire logic [7:0]           status,
    output fdsp_pkg::fdsp_frame_t     frame,
    output logic                      data_out,
    output logic                      data_oe
);
    import fdsp_pkg::*;

    logic [8:0]  sync1_reg, sync2_reg, sync3_reg, filt_reg;
    logic        in_frame_reg;
    logic        out_en_reg;
    logic        out_src_reg;
    logic [7:0]  out_sr_reg;
    logic [2:0]  out_cnt_reg;
    logic [15:0] hdr_bits;
    logic [7:0]  op_next;

    assign hdr_bits = filt_reg[8] ? `FDSP_HDR_WIDE : `FDSP_HDR_NARROW;
    assign op_next  = {frame.opcode[6:0], data_in};

    // Mode and status arrive from the system clock; each bit is filtered on its own.
    always_ff @(posedge serial_clk or posedge select_n)
    begin
        if (select_n)
        begin
            sync1_reg <= 9'h000;
            sync2_reg <= 9'h000;
            sync3_reg <= 9'h000;
            filt_reg  <= 9'h000;
        end
        else
        begin
            sync1_reg <= {wide_mode, status};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg  <= (~(sync2_reg ^ sync3_reg) & sync3_reg) | ((sync2_reg ^ sync3_reg) & filt_reg);
        end
    end

    always_ff @(posedge serial_clk or posedge select_n)
    begin
        if (select_n)
            in_frame_reg <= 1'b0;
        else
            in_frame_reg <= 1'b1;
    end

    // Frame contents survive the end of the frame so the system side can decode them.
    always_ff @(posedge serial_clk or posedge link_rst)
    begin
        if (link_rst)
            frame <= '0;
        else if (!in_frame_reg)
        begin
            frame.opcode    <= {7'h00, data_in};
            frame.addr      <= 32'h0000_0000;
            frame.data      <= 8'h00;
            frame.bit_count <= 16'h0001;
            frame.frame_tog <= ~frame.frame_tog;
        end
        else
        begin
            if (frame.bit_count != 16'hffff)
                frame.bit_count <= frame.bit_count + 16'h0001;
            if (frame.bit_count < `FDSP_BYTE_BITS)
                frame.opcode <= op_next;
            else if (frame.bit_count < hdr_bits)
                frame.addr <= {frame.addr[30:0], data_in};
            else
                frame.data <= {frame.data[6:0], data_in};
        end
    end

    always_ff @(posedge serial_clk or posedge select_n)
    begin
        if (select_n)
        begin
            out_en_reg  <= 1'b0;
            out_src_reg <= 1'b0;
            out_sr_reg  <= 8'h00;
            out_cnt_reg <= 3'h0;
        end
        else if (!out_en_reg)
        begin
            if (in_frame_reg && frame.bit_count == 16'h0007 && op_next == `FDSP_OP_READ_STATUS)
            begin
                out_en_reg  <= 1'b1;
                out_src_reg <= 1'b1;
                out_sr_reg  <= filt_reg[7:0];
            end
            else if (in_frame_reg && frame.opcode == `FDSP_OP_READ && frame.bit_count == hdr_bits - 16'h0001
                     && !filt_reg[`FDSP_ST_WIP])
            begin
                out_en_reg  <= 1'b1;
                out_src_reg <= 1'b0;
                out_sr_reg  <= `FDSP_READ_FILL;
            end
        end
        else
        begin
            out_cnt_reg <= out_cnt_reg + 3'h1;
            if (out_cnt_reg == 3'h7)
                out_sr_reg <= out_src_reg ? filt_reg[7:0] : `FDSP_READ_FILL;
            else
                out_sr_reg <= {out_sr_reg[6:0], 1'b0};
        end
    end

    always_ff @(negedge serial_clk or posedge select_n)
    begin
        if (select_n)
        begin
            data_out <= 1'b0;
            data_oe  <= 1'b0;
        end
        else
        begin
            data_out <= out_sr_reg[7];
            data_oe  <= out_en_reg;
        end
    end

endmodule // fdsp_link_shifter

//--- rtl/fdsp_command_port.sv
// Summary of operation
// - Address and data move one bit at a time, most significant bit first.
// - With select low, each bit is sampled on a rising serial clock edge.
// - Reads shift data out; host may raise select after any output bit.
// - Program and erase run only if select rises on a byte boundary.
// - While a cycle runs, every access except read-status is rejected and the cycle goes on.
// - Addressing starts in three-byte mode from the factory state.
// - Four-byte mode uses 32-bit addresses and reaches the whole array.
// - Enter-wide switches to four-byte mode at once and survives reset_n.
// - Only exit-wide or the factory reset returns the device to three-byte addressing.
// - The 128 Mb part decodes 256 sectors of sixteen 4 KB subsectors.
// - The 256 Mb part decodes 512 sectors and 8192 subsectors linearly.
// - The 512 Mb part decodes 1024 sectors and 16384 subsectors.
// - Block-protect bits at 6, 4, 3 and 2 are writable and reset to zero.
// - Status bit 5 set places the protected region at the bottom.
// - Write-enable latch at bit 1 gates program, status write and erases.
// - Status bit 0 reads one while a write or erase cycle runs.
// - Protected sectors refuse program and erase; bulk erase needs no protection.
`timescale 1ns/1ps
`include "fdsp_defs.svh"

module fdsp_command_port
#(
    parameter fdsp_pkg::fdsp_density_t DENSITY = fdsp_pkg::FDSP_D512,
    parameter int unsigned SUB_ERASE_CYCLES  = (`FDSP_T_SUB_ERASE_NS + `FDSP_CLK_PERIOD_NS - 1) / `FDSP_CLK_PERIOD_NS,
    parameter int unsigned SECT_ERASE_CYCLES = (`FDSP_T_SECT_ERASE_NS + `FDSP_CLK_PERIOD_NS - 1) / `FDSP_CLK_PERIOD_NS,
    parameter int unsigned BULK_ERASE_CYCLES = (`FDSP_T_BULK_ERASE_NS + `FDSP_CLK_PERIOD_NS - 1) / `FDSP_CLK_PERIOD_NS
)
(
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    input  wire logic                 factory_reset_n,
    input  wire logic                 select_n,
    input  wire logic                 serial_clk,
    input  wire logic                 data_in,
    output logic                      data_out,
    output logic                      data_oe,
    output logic [7:0]                flash_status,
    output logic                      wide_mode,
    output fdsp_pkg::fdsp_cmd_t       cmd,
    output logic                      cmd_valid
);
    import fdsp_pkg::*;

    localparam int unsigned STATUS_WR_CYCLES = (`FDSP_T_STATUS_WR_NS + `FDSP_CLK_PERIOD_NS - 1) / `FDSP_CLK_PERIOD_NS;
    localparam int unsigned PROG_CYCLES = (`FDSP_T_PROG_NS + `FDSP_CLK_PERIOD_NS - 1) / `FDSP_CLK_PERIOD_NS;

    fdsp_state_t state_reg;
    fdsp_frame_t frame;
    fdsp_cmd_t   cmd_next;
    logic        link_rst_reg;
    logic        sel_s1_reg, sel_s2_reg, sel_s3_reg, sel_f_reg;
    logic        tog_s1_reg, tog_s2_reg, tog_s3_reg, tog_seen_reg;
    logic        frame_end_reg;
    logic [31:0] busy_cnt_reg;
    logic [31:0] start_cycles;
    logic        start_req, wel_set, wel_clr, wide_set, wide_clr, st_write, emit;
    logic        byte_ok, op_ok, new_frame;
    logic [15:0] hdr_bits;
    logic [9:0]  sect_mask;
    logic [9:0]  sector;
    logic [13:0] subsector;
    logic [3:0]  bp;
    logic        prot;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial clock domain.

    fdsp_link_shifter link_u
    (
        .serial_clk (serial_clk),
        .select_n   (select_n),
        .link_rst   (link_rst_reg),
        .data_in    (data_in),
        .wide_mode  (wide_mode),
        .status     (flash_status),
        .frame      (frame),
        .data_out   (data_out),
        .data_oe    (data_oe)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Frame boundary crossing.

    // A frame ends when the filtered select rises; the toggle marks that clock edges really came.
    always_ff @(posedge mclk)
    begin
        link_rst_reg <= ~reset_n;
        if (!reset_n)
        begin
            sel_s1_reg    <= 1'b1;
            sel_s2_reg    <= 1'b1;
            sel_s3_reg    <= 1'b1;
            sel_f_reg     <= 1'b1;
            tog_s1_reg    <= 1'b0;
            tog_s2_reg    <= 1'b0;
            tog_s3_reg    <= 1'b0;
            frame_end_reg <= 1'b0;
            tog_seen_reg  <= 1'b0;
        end
        else
        begin
            sel_s1_reg    <= select_n;
            sel_s2_reg    <= sel_s1_reg;
            sel_s3_reg    <= sel_s2_reg;
            tog_s1_reg    <= frame.frame_tog;
            tog_s2_reg    <= tog_s1_reg;
            tog_s3_reg    <= tog_s2_reg;
            if (sel_s2_reg == sel_s3_reg)
                sel_f_reg <= sel_s3_reg;
            frame_end_reg <= !sel_f_reg && sel_s2_reg && sel_s3_reg;
            if (new_frame)
                tog_seen_reg <= tog_s3_reg;
        end
    end

    assign new_frame = frame_end_reg && (tog_s2_reg == tog_s3_reg) && (tog_s3_reg != tog_seen_reg);

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode and protection.

    function automatic logic sect_protected(input logic [9:0] sect, input logic [3:0] bpv,
                                            input logic tb, input logic [9:0] mask);
        logic [15:0] span;
        logic        res;
        span = 16'h0001 << (bpv - 4'h1);
        res  = 1'b0;
        if (bpv == 4'h0)
            res = 1'b0;
        else if (span > {6'h00, mask})
            res = 1'b1;
        else if (tb)
            res = {6'h00, sect} < span;
        else
            res = {6'h00, sect} > ({6'h00, mask} - span);
        return res;
    endfunction

    assign sect_mask = (DENSITY == FDSP_D128) ? 10'h0ff :
                       (DENSITY == FDSP_D256) ? 10'h1ff : 10'h3ff;

    assign hdr_bits  = wide_mode ? `FDSP_HDR_WIDE : `FDSP_HDR_NARROW;
    assign sector    = frame.addr[`FDSP_SECT_LSB +: 10] & sect_mask;
    assign subsector = frame.addr[`FDSP_SUB_LSB +: 14] & {sect_mask, 4'hf};
    assign bp        = {flash_status[`FDSP_ST_BP_HI], flash_status[`FDSP_ST_BP_MID],
                        flash_status[`FDSP_ST_BP_LO], flash_status[`FDSP_ST_BP_LSB]};
    assign prot      = sect_protected(sector, bp, flash_status[`FDSP_ST_TB], sect_mask);
    assign byte_ok   = frame.bit_count[2:0] == 3'h0;
    assign op_ok     = new_frame && state_reg == FDSP_IDLE;

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode at the end of a frame.

    always_comb
    begin
        start_req    = 1'b0;
        start_cycles = 32'h0000_0000;
        wel_set      = 1'b0;
        wel_clr      = 1'b0;
        wide_set     = 1'b0;
        wide_clr     = 1'b0;
        st_write     = 1'b0;
        emit         = 1'b0;
        cmd_next     = '{FDSP_CMD_PROGRAM, frame.addr, sector, subsector, frame.data};
        if (op_ok)
        begin
            case (frame.opcode)
                `FDSP_OP_WRITE_ENABLE:  wel_set = 1'b1;
                `FDSP_OP_WRITE_DISABLE: wel_clr = 1'b1;
                `FDSP_OP_WIDE_ENTER:    wide_set = 1'b1;
                `FDSP_OP_WIDE_EXIT:     wide_clr = 1'b1;
                `FDSP_OP_WRITE_STATUS:
                begin
                    if (byte_ok && frame.bit_count == 16'h0010 && flash_status[`FDSP_ST_WEL])
                    begin
                        st_write     = 1'b1;
                        start_req    = 1'b1;
                        start_cycles = STATUS_WR_CYCLES;
                    end
                end
                `FDSP_OP_PROGRAM:
                begin
                    if (byte_ok && frame.bit_count >= hdr_bits + `FDSP_BYTE_BITS
                        && flash_status[`FDSP_ST_WEL] && !prot)
                    begin
                        emit          = 1'b1;
                        cmd_next.kind = FDSP_CMD_PROGRAM;
                        start_req     = 1'b1;
                        start_cycles  = PROG_CYCLES;
                    end
                end
                `FDSP_OP_SECT_ERASE, `FDSP_OP_SUB_ERASE:
                begin
                    if (byte_ok && frame.bit_count == hdr_bits && flash_status[`FDSP_ST_WEL] && !prot)
                    begin
                        emit          = 1'b1;
                        start_req     = 1'b1;
                        cmd_next.kind = (frame.opcode == `FDSP_OP_SECT_ERASE) ? FDSP_CMD_SECT_ERASE
                                                                               : FDSP_CMD_SUB_ERASE;
                        start_cycles  = (frame.opcode == `FDSP_OP_SECT_ERASE) ? SECT_ERASE_CYCLES : SUB_ERASE_CYCLES;
                    end
                end
                `FDSP_OP_BULK_ERASE, `FDSP_OP_DIE_ERASE:
                begin
                    if (byte_ok && flash_status[`FDSP_ST_WEL] && bp == 4'h0)
                    begin
                        emit          = 1'b1;
                        cmd_next.kind = (frame.opcode == `FDSP_OP_BULK_ERASE) ? FDSP_CMD_BULK_ERASE
                                                                               : FDSP_CMD_DIE_ERASE;
                        start_req     = 1'b1;
                        start_cycles  = BULK_ERASE_CYCLES;
                    end
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Internal cycle timer.

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            state_reg    <= FDSP_IDLE;
            busy_cnt_reg <= 32'h0000_0000;
        end
        else
        begin
            case (state_reg)
                FDSP_IDLE:
                begin
                    if (start_req)
                    begin
                        state_reg    <= FDSP_BUSY;
                        busy_cnt_reg <= start_cycles - 32'h0000_0001;
                    end
                end
                FDSP_BUSY:
                begin
                    if (busy_cnt_reg == 32'h0000_0000)
                        state_reg <= FDSP_IDLE;
                    else
                        busy_cnt_reg <= busy_cnt_reg - 32'h0000_0001;
                end
                default: state_reg <= FDSP_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status register.

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
            flash_status <= `FDSP_ST_RESET;
        else
        begin
            if (st_write)
                flash_status[7:2] <= frame.addr[7:2];
            if (start_req)
                flash_status[`FDSP_ST_WIP] <= 1'b1;
            else if (state_reg == FDSP_BUSY && busy_cnt_reg == 32'h0000_0000)
                flash_status[`FDSP_ST_WIP] <= 1'b0;
            if (wel_set)
                flash_status[`FDSP_ST_WEL] <= 1'b1;
            else if (wel_clr || (state_reg == FDSP_BUSY && busy_cnt_reg == 32'h0000_0000))
                flash_status[`FDSP_ST_WEL] <= 1'b0;
        end
    end

    // Addressing mode is nonvolatile: only exit-wide or the factory reset clears it.
    always_ff @(posedge mclk)
    begin
        if (!factory_reset_n)
            wide_mode <= 1'b0;
        else if (wide_set)
            wide_mode <= 1'b1;
        else if (wide_clr)
            wide_mode <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            cmd       <= '0;
            cmd_valid <= 1'b0;
        end
        else
        begin
            cmd_valid <= emit;
            if (emit)
                cmd <= cmd_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    wip_tracks_busy_a: assert property (flash_status[`FDSP_ST_WIP] == (state_reg == FDSP_BUSY))
        else $error("busy flag disagrees with cycle state");
    busy_holds_a: assert property ($rose(flash_status[`FDSP_ST_WIP]) |-> flash_status[`FDSP_ST_WIP] [*8])
        else $error("busy flag dropped too early");
    busy_reject_a: assert property (new_frame && state_reg == FDSP_BUSY |=> !cmd_valid && $stable(wide_mode))
        else $error("access accepted during a cycle");
    mid_byte_a: assert property (new_frame && !byte_ok |=> !cmd_valid && !$rose(flash_status[`FDSP_ST_WIP]))
        else $error("mid-byte frame executed");
    wel_gate_a: assert property (cmd_valid |-> $past(flash_status[`FDSP_ST_WEL]))
        else $error("write ran without enable latch");
    bulk_prot_a: assert property (cmd_valid && cmd.kind inside {FDSP_CMD_BULK_ERASE, FDSP_CMD_DIE_ERASE}
                                  |-> $past(bp) == 4'h0)
        else $error("bulk erase with protection set");
    wide_enter_a: assert property (op_ok && frame.opcode == `FDSP_OP_WIDE_ENTER && factory_reset_n
                                   |=> wide_mode)
        else $error("wide mode not entered");
    wide_keep_a: assert property (wide_mode && factory_reset_n && !wide_clr |=> wide_mode)
        else $error("wide mode left without exit");
    sect_map_a: assert property (cmd_valid |-> cmd.subsector[13:4] == cmd.sector)
        else $error("subsector outside its sector");

endmodule // fdsp_command_port

//--- testbench/fdsp_host_model.sv
`timescale 1ns/1ps
module fdsp_host_model
(
    output logic      select_n,
    output logic      serial_clk,
    input  wire logic data_out,
    output logic      data_in
);
    initial
    begin
        select_n = 1'b1;
        serial_clk = 1'b0;
        data_in = 1'b0;
    end

    // Sends n bits MSB first and keeps the last eight sampled.
    task automatic frame(input logic [47:0] bits, input int n, output logic [7:0] rd);
        select_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            data_in = bits[i];
            #6 serial_clk = 1'b1;
            rd = {rd[6:0], data_out};
            #6 serial_clk = 1'b0;
        end
        #6 select_n = 1'b1;
        data_in = ~data_in;
        #400;
    endtask
endmodule // fdsp_host_model

//--- testbench/serial_flash_command_port_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t got %h", $time, a); end end
module serial_flash_command_port_test;
    import fdsp_pkg::*;
    logic       mclk = 1'b0;
    logic       reset_n = 1'b0;
    logic       factory_reset_n = 1'b0;
    wire        select_n, serial_clk, data_in;
    logic       data_out, data_oe, wide_mode, cmd_valid;
    logic [7:0] flash_status, rd;
    fdsp_cmd_t  cmd, cmd128;
    int         failures = 0;
    int         total_checks = 0;
    int         nval = 0;
    int         oe_bits = 0;
    int         cyc = 0;

    always #20 mclk = ~mclk;

    fdsp_command_port #(.SUB_ERASE_CYCLES(20), .SECT_ERASE_CYCLES(30), .BULK_ERASE_CYCLES(40)) dut
    (
        .mclk(mclk), .reset_n(reset_n), .factory_reset_n(factory_reset_n), .select_n(select_n),
        .serial_clk(serial_clk), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .flash_status(flash_status), .wide_mode(wide_mode), .cmd(cmd), .cmd_valid(cmd_valid)
    );

    fdsp_host_model host
    (
        .select_n(select_n), .serial_clk(serial_clk), .data_out(data_out), .data_in(data_in)
    );

    // A 128 Mb part listens to the same frames so its sector map can be checked.
    fdsp_command_port
    #(
        .DENSITY(FDSP_D128), .SUB_ERASE_CYCLES(20), .SECT_ERASE_CYCLES(30), .BULK_ERASE_CYCLES(40)
    ) dut128
    (
        .mclk(mclk), .reset_n(reset_n), .factory_reset_n(factory_reset_n), .select_n(select_n),
        .serial_clk(serial_clk), .data_in(data_in), .data_out(), .data_oe(), .flash_status(),
        .wide_mode(), .cmd(cmd128), .cmd_valid()
    );

    // Counts the bits during which the device drives the data line.
    always @(posedge serial_clk)
    begin
        if (data_oe === 1'b1)
            oe_bits++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk)
    begin
        if (cmd_valid === 1'b1)
            nval++;
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            stop_test();
        end
    end

    task automatic stop_test;
        if (failures == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic op(input logic [47:0] b, input int n);
        host.frame(b, n, rd);
        cycles(1);
    endtask

    task automatic rdsr(input logic [7:0] exp);
        op(48'h0500, 16);
        `CHK(rd, exp)
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        cycles(4);
        reset_n = 1'b1;
        factory_reset_n = 1'b1;
        cycles(2);
        `CHK(wide_mode, 1'b0)
        rdsr(8'h00);
        op(48'h02001000a5, 40);
        `CHK(nval, 0)
        op(48'h06, 8);
        rdsr(8'h02);
        op(48'h0300000000, 40);
        `CHK(rd, 8'hff)
        `CHK(oe_bits, 24)
        op(48'h01b8, 16);
        cycles(130);
        `CHK(flash_status, 8'hb8)
        op(48'h06, 8);
        op(48'h02001000a5, 40);
        op(48'hc7, 8);
        `CHK(nval, 0)
        op(48'h0110000052ff, 47);
        `CHK(nval, 0)
        op(48'h02200000a5, 40);
        `CHK(nval, 1)
        `CHK(cmd.kind, FDSP_CMD_PROGRAM)
        `CHK(cmd.addr, 32'h00200000)
        `CHK(cmd.data, 8'ha5)
        `CHK(flash_status[0], 1'b1)
        op(48'h02200000a5, 40);
        op(48'h0300000000, 40);
        `CHK(nval, 1)
        `CHK(oe_bits, 24)
        cycles(2010);
        `CHK(flash_status, 8'hb8)
        op(48'hb7, 8);
        `CHK(wide_mode, 1'b1)
        reset_n = 1'b0;
        cycles(4);
        reset_n = 1'b1;
        cycles(2);
        `CHK(wide_mode, 1'b1)
        op(48'h06, 8);
        op(48'h2003fff000, 40);
        `CHK(cmd.subsector, 14'd16383)
        `CHK(cmd.sector, 10'd1023)
        `CHK(cmd.kind, FDSP_CMD_SUB_ERASE)
        `CHK(cmd128.subsector, 14'd4095)
        `CHK(cmd128.sector, 10'd255)
        cycles(30);
        op(48'he9, 8);
        `CHK(wide_mode, 1'b0)
        op(48'h06, 8);
        op(48'hc7, 8);
        `CHK(nval, 3)
        `CHK(cmd.kind, FDSP_CMD_BULK_ERASE)
        stop_test();
    end
endmodule // serial_flash_command_port_test
